// ==== include/irptx_pkg.sv ====
// Behaviour
// - A byte in the holding register moves to the shifter, which then serialises it.
// - With holding-empty interrupt enabled, interrupt rises when holding moves to shifter.
// - Enabling the interrupt while holding-empty is pending raises it at once.
// - Holding-empty interrupt can be disabled, then later transfers raise nothing.
// - Status shows holding empty at 0x10 and transmission complete at 0x20.
// - Holding-empty set while holding has no byte, cleared by a new write.
// - Completion flag follows the shifted byte and clears when status is read.
// - Control-status bit 0 enables the serial transmitter.
// - The transmitter must be enabled before bytes can be sent; the pulse timer need not run.
// - Period is denominator, compare is numerator of the pulse-width multiplier.
// - Pulse timer is a modulator making pulses in step with the serial bits.
// - Pulse timer control bit 0 starts the timer, clearing halts it.
// - Third transmitter data register is unused and reads zero.
// - One frame bit is sent every eight bit-rate clock cycles.
// - Optical output is the pulse timer output, OR the serial zero bits while the pulse timer is halted.
// - Same clocks and defaults give a pulse one eighth of a bit wide.
package irptx_pkg;
    // =========================================================
    // Register offsets
    localparam logic [3:0] TX_FUNCTION_SELECT_OFS       = 4'h0;
    localparam logic [3:0] TX_CLOCK_INPUT_SELECT_OFS    = 4'h1;
    localparam logic [3:0] TX_OUTPUT_ROUTE_OFS          = 4'h2;
    localparam logic [3:0] TX_SHIFT_DATA_OFS            = 4'h3;
    localparam logic [3:0] TX_HOLDING_DATA_OFS          = 4'h4;
    localparam logic [3:0] TX_SPARE_DATA_OFS            = 4'h5;
    localparam logic [3:0] TX_CONTROL_STATUS_OFS        = 4'h6;
    localparam logic [3:0] PULSE_FUNCTION_SELECT_OFS    = 4'h7;
    localparam logic [3:0] PULSE_CLOCK_INPUT_SELECT_OFS = 4'h8;
    localparam logic [3:0] PULSE_OUTPUT_ROUTE_OFS       = 4'h9;
    localparam logic [3:0] PULSE_COUNT_VALUE_OFS        = 4'hA;
    localparam logic [3:0] PULSE_PERIOD_VALUE_OFS       = 4'hB;
    localparam logic [3:0] PULSE_COMPARE_VALUE_OFS      = 4'hC;
    localparam logic [3:0] PULSE_CONTROL_OFS            = 4'hD;
    localparam logic [3:0] TX_IRQ_ENABLE_OFS            = 4'hE;
    // =========================================================
    // Field positions
    localparam int TX_ENABLE_BIT      = 0;
    localparam int HOLD_EMPTY_BIT     = 4;
    localparam int TX_COMPLETE_BIT    = 5;
    localparam int PULSE_START_BIT    = 0;
    localparam int IRQ_ENABLE_BIT     = 0;
    localparam logic [7:0] HOLD_EMPTY_MASK  = 8'h10;
    localparam logic [7:0] TX_COMPLETE_MASK = 8'h20;
    // =========================================================
    // Reset values
    localparam logic [7:0] TX_FUNCTION_RST     = 8'h0D;
    localparam logic [7:0] TX_INPUT_RST        = 8'h00;
    localparam logic [7:0] PULSE_FUNCTION_RST  = 8'h21;
    localparam logic [7:0] PULSE_INPUT_RST     = 8'h10;
    localparam logic [7:0] ROUTE_RST           = 8'h00;
    localparam logic [7:0] PULSE_PERIOD_RST    = 8'h07;
    localparam logic [7:0] PULSE_COMPARE_RST   = 8'h01;
    // =========================================================
    // Frame timing
    localparam logic [2:0] SUBTICK_LAST = 3'h7;  // Eight bit-rate ticks per bit
    localparam logic [3:0] FRAME_LAST   = 4'h9;  // Start, eight data, stop
    typedef enum logic {IRPTX_IDLE, IRPTX_SEND} irptx_state_t;
endpackage : irptx_pkg

// ==== src/irptx_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module irptx_top (
    // Clock and reset
    input  wire logic                  i_mclk,
    input  wire logic                  i_reset,
    // Register port
    input  wire logic [3:0]            i_addr,
    input  wire logic [7:0]            i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [7:0]            o_rdata,
    // Interrupt and line outputs
    output logic                       o_irq,
    output logic                       o_serial,
    output logic                       o_pulse,
    output logic                       o_optical
);
    import irptx_pkg::*;

    // =========================================================
    // Register storage
    logic [7:0]   tx_function_select;
    logic [7:0]   tx_clock_input_select;
    logic [7:0]   tx_output_route;
    logic [7:0]   pulse_function_select;
    logic [7:0]   pulse_clock_input_select;
    logic [7:0]   pulse_output_route;
    logic [7:0]   pulse_period_value;
    logic [7:0]   pulse_compare_value;

    // Control bits and flags
    logic         pulse_start;
    logic         tx_enable;
    logic         irq_enable;
    logic [7:0]   holding_data;
    logic         holding_empty;
    logic         tx_complete;

    // Transmit datapath and counters
    logic [7:0]   shift_data;
    logic [7:0]   pulse_count;
    irptx_state_t state;
    logic [2:0]   subtick;
    logic [3:0]   frame_bit;
    logic [3:0]   baud_div;
    logic [3:0]   pulse_div;
    // Internal strobes
    logic         bit_tick;
    logic         pulse_tick;
    logic         load_now;
    logic         bit_start;
    logic         bit_zero;
    logic         status_read;
    logic         hold_write;
    logic [7:0]   pulse_elapsed;

    // Strobes decoded from the register index
    assign hold_write  = i_wr && (i_addr == TX_HOLDING_DATA_OFS);
    assign status_read = i_rd && (i_addr == TX_CONTROL_STATUS_OFS);

    // Plain read/write registers
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            tx_function_select       <= TX_FUNCTION_RST;
            tx_clock_input_select    <= TX_INPUT_RST;
            tx_output_route          <= ROUTE_RST;
            pulse_function_select    <= PULSE_FUNCTION_RST;
            pulse_clock_input_select <= PULSE_INPUT_RST;
            pulse_output_route       <= ROUTE_RST;
            pulse_period_value       <= PULSE_PERIOD_RST;
            pulse_compare_value      <= PULSE_COMPARE_RST;
            pulse_start              <= 1'b0;
            tx_enable                <= 1'b0;
            irq_enable               <= 1'b0;
        end else if (i_wr) begin
            unique case (i_addr)
                TX_FUNCTION_SELECT_OFS:       tx_function_select <= i_wdata;
                TX_CLOCK_INPUT_SELECT_OFS:    tx_clock_input_select <= i_wdata;
                TX_OUTPUT_ROUTE_OFS:          tx_output_route <= i_wdata;
                PULSE_FUNCTION_SELECT_OFS:    pulse_function_select <= i_wdata;
                PULSE_CLOCK_INPUT_SELECT_OFS: pulse_clock_input_select <= i_wdata;
                PULSE_OUTPUT_ROUTE_OFS:       pulse_output_route <= i_wdata;
                PULSE_PERIOD_VALUE_OFS:       pulse_period_value <= i_wdata;
                PULSE_COMPARE_VALUE_OFS:      pulse_compare_value <= i_wdata;
                PULSE_CONTROL_OFS:            pulse_start <= i_wdata[PULSE_START_BIT];
                TX_CONTROL_STATUS_OFS:        tx_enable <= i_wdata[TX_ENABLE_BIT];
                TX_IRQ_ENABLE_OFS:            irq_enable <= i_wdata[IRQ_ENABLE_BIT];
                default: ;
            endcase
        end
    end

    // Read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                TX_FUNCTION_SELECT_OFS:       o_rdata <= tx_function_select;
                TX_CLOCK_INPUT_SELECT_OFS:    o_rdata <= tx_clock_input_select;
                TX_OUTPUT_ROUTE_OFS:          o_rdata <= tx_output_route;
                TX_SHIFT_DATA_OFS:            o_rdata <= shift_data;
                TX_CONTROL_STATUS_OFS:        o_rdata <= {2'b00, tx_complete, holding_empty,
                                                          3'b000, tx_enable};
                PULSE_FUNCTION_SELECT_OFS:    o_rdata <= pulse_function_select;
                PULSE_CLOCK_INPUT_SELECT_OFS: o_rdata <= pulse_clock_input_select;
                PULSE_OUTPUT_ROUTE_OFS:       o_rdata <= pulse_output_route;
                PULSE_COUNT_VALUE_OFS:        o_rdata <= pulse_count;
                PULSE_PERIOD_VALUE_OFS:       o_rdata <= pulse_period_value;
                PULSE_COMPARE_VALUE_OFS:      o_rdata <= pulse_compare_value;
                PULSE_CONTROL_OFS:            o_rdata <= {7'h00, pulse_start};
                TX_IRQ_ENABLE_OFS:            o_rdata <= {7'h00, irq_enable};
                default:                      o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // =========================================================
    // Clock dividers: low nibble of each input select is divide-by minus one
    always_ff @(posedge i_mclk) begin
        if (i_reset || !tx_enable) begin
            baud_div <= 4'h0;
        end else if (baud_div == 4'h0) begin
            baud_div <= tx_clock_input_select[3:0];
        end else begin
            baud_div <= baud_div - 4'h1;
        end
    end
    assign bit_tick = tx_enable && (baud_div == 4'h0);

    // Pulse divider restarts at each bit start to stay in step
    always_ff @(posedge i_mclk) begin
        if (i_reset || bit_start || !pulse_start) begin
            pulse_div <= pulse_clock_input_select[3:0];
        end else if (pulse_div == 4'h0) begin
            pulse_div <= pulse_clock_input_select[3:0];
        end else begin
            pulse_div <= pulse_div - 4'h1;
        end
    end
    assign pulse_tick = pulse_start && (pulse_div == 4'h0);

    // =========================================================
    // Transmit state machine
    assign load_now  = bit_tick && !holding_empty &&
                       ((state == IRPTX_IDLE) ||
                        (subtick == SUBTICK_LAST && frame_bit == FRAME_LAST));
    assign bit_start = load_now || (bit_tick && state == IRPTX_SEND &&
                                    subtick == SUBTICK_LAST && frame_bit != FRAME_LAST);

    // Frame sequencing, eight ticks per bit
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            state      <= IRPTX_IDLE;
            subtick    <= 3'h0;
            frame_bit  <= 4'h0;
            shift_data <= 8'h00;
        end else if (load_now) begin
            state      <= IRPTX_SEND;
            subtick    <= 3'h0;
            frame_bit  <= 4'h0;
            shift_data <= holding_data;
        end else if (bit_tick && state == IRPTX_SEND) begin
            subtick <= subtick + 3'h1;
            if (subtick == SUBTICK_LAST) begin
                if (frame_bit == FRAME_LAST) begin
                    state <= IRPTX_IDLE;
                end else begin
                    frame_bit <= frame_bit + 4'h1;
                end
                if (frame_bit != 4'h0 && frame_bit != FRAME_LAST) begin
                    shift_data <= {1'b0, shift_data[7:1]};
                end
            end
        end
    end

    // Serial line: start low, data LSB first, stop and idle high
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_serial <= 1'b1;
        end else if (load_now) begin
            o_serial <= 1'b0;
        end else if (bit_tick && state == IRPTX_SEND && subtick == SUBTICK_LAST) begin
            if (frame_bit == FRAME_LAST) begin
                o_serial <= 1'b1;
            end else if (frame_bit == 4'h8) begin
                o_serial <= 1'b1;                                       // Stop bit
            end else if (frame_bit == 4'h0) begin
                o_serial <= shift_data[0];
            end else begin
                o_serial <= shift_data[1];
            end
        end
    end
    // Low line inside a frame marks a zero bit
    assign bit_zero = (state == IRPTX_SEND) && !o_serial;

    // Holding register and empty flag; a write wins over the transfer
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            holding_data  <= 8'h00;
            holding_empty <= 1'b1;
        end else if (hold_write) begin
            holding_data  <= i_wdata;
            holding_empty <= 1'b0;
        end else if (load_now) begin
            holding_empty <= 1'b1;
        end
    end

    // Completion flag: set by a transfer, cleared by a status read, set wins
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            tx_complete <= 1'b0;
        end else if (load_now) begin
            tx_complete <= 1'b1;
        end else if (status_read) begin
            tx_complete <= 1'b0;
        end
    end

    // Interrupt level: empty holding register gated by enable
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= irq_enable && (holding_empty || load_now);
        end
    end

    // =========================================================
    // Pulse width timer: reloads each bit, counts down on pulse ticks
    always_ff @(posedge i_mclk) begin
        if (i_reset || !pulse_start) begin
            pulse_count <= 8'h00;
        end else if (bit_start) begin
            pulse_count <= pulse_period_value;
        end else if (pulse_tick && pulse_count != 8'h00) begin
            pulse_count <= pulse_count - 8'h01;
        end
    end
    // Pulse ticks spent since the bit began
    assign pulse_elapsed = pulse_period_value - pulse_count;

    // Pulse high for the first compare ticks of each zero bit
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_pulse <= 1'b0;
        end else begin
            o_pulse <= pulse_start && bit_zero && !bit_start &&
                       (pulse_elapsed < pulse_compare_value);
        end
    end

    // Combined optical output; serial contributes its zero bits only
    // while the pulse timer is halted
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_optical <= 1'b0;
        end else begin
            o_optical <= o_pulse | (!pulse_start && bit_zero);
        end
    end

    // =========================================================
    // Checks

    // A transfer empties holding and marks the byte in flight
    a_empty_on_load: assert property (
        @(posedge i_mclk) disable iff (i_reset)
        load_now && !hold_write |=> holding_empty && tx_complete)
        else $error("transfer did not empty holding and set complete");

    // Enabled interrupt follows a transfer
    a_irq_on_load: assert property (
        @(posedge i_mclk) disable iff (i_reset)
        irq_enable && load_now |=> o_irq)
        else $error("no interrupt on holding transfer");

    // Pending empty shows as soon as the enable lands
    a_irq_pending: assert property (
        @(posedge i_mclk) disable iff (i_reset)
        $rose(irq_enable) && holding_empty && !hold_write |=> o_irq)
        else $error("pending empty not signalled on enable");

    // Disabled interrupt stays low
    a_irq_masked: assert property (
        @(posedge i_mclk) disable iff (i_reset)
        !irq_enable |=> !o_irq)
        else $error("interrupt while disabled");

    // A holding write always fills the register
    a_write_clears_empty: assert property (
        @(posedge i_mclk) disable iff (i_reset)
        hold_write |=> !holding_empty)
        else $error("write left holding empty");

    // Status read clears completion unless a transfer coincides
    a_read_clears_done: assert property (
        @(posedge i_mclk) disable iff (i_reset)
        status_read && !load_now |=> !tx_complete)
        else $error("status read did not clear complete");

    // Status bits read back at their masks
    a_status_layout: assert property (
        @(posedge i_mclk) disable iff (i_reset)
        status_read |=> o_rdata[HOLD_EMPTY_BIT] == $past(holding_empty)
        && o_rdata[TX_COMPLETE_BIT] == $past(tx_complete))
        else $error("status bits misplaced");

    // Nothing moves while the transmitter is off
    a_disabled_idle: assert property (
        @(posedge i_mclk) disable iff (i_reset)
        !tx_enable |-> !load_now)
        else $error("transfer while transmitter disabled");

    // Spare register reads zero
    a_spare_zero: assert property (
        @(posedge i_mclk) disable iff (i_reset)
        i_rd && i_addr == TX_SPARE_DATA_OFS |=> o_rdata == 8'h00)
        else $error("spare register not zero");

    // Frame opens with a low start bit
    a_start_low: assert property (
        @(posedge i_mclk) disable iff (i_reset)
        load_now |=> !o_serial)
        else $error("start bit not low");

    // No pulse during a one bit
    a_quiet_ones: assert property (
        @(posedge i_mclk) disable iff (i_reset)
        o_serial |=> !o_pulse)
        else $error("pulse during a one bit");

    // Halted timer holds count and output at zero
    a_halted_timer: assert property (
        @(posedge i_mclk) disable iff (i_reset)
        !pulse_start |=> pulse_count == 8'h00 && !o_pulse)
        else $error("timer runs while halted");

    // Timer pulses reach the optical output
    a_or_output: assert property (
        @(posedge i_mclk) disable iff (i_reset)
        pulse_start && o_pulse |=> o_optical)
        else $error("pulse missing on optical output");

    // The line only changes where a bit begins
    a_bit_hold: assert property (
        @(posedge i_mclk) disable iff (i_reset)
        !bit_start |=> $stable(o_serial))
        else $error("serial line changed inside a bit");

    // Stop bit is high for its whole length
    a_stop_high: assert property (
        @(posedge i_mclk) disable iff (i_reset)
        state == IRPTX_SEND && frame_bit == FRAME_LAST |-> o_serial)
        else $error("stop bit not high");

    // First data bit is the least significant one
    a_lsb_first: assert property (
        @(posedge i_mclk) disable iff (i_reset)
        bit_start && state == IRPTX_SEND && frame_bit == 4'h0 |=> o_serial == $past(shift_data[0]))
        else $error("first data bit not least significant");

    // Default settings give a pulse of one tick
    a_pulse_width: assert property (
        @(posedge i_mclk) disable iff (i_reset)
        pulse_compare_value == PULSE_COMPARE_RST && pulse_period_value == PULSE_PERIOD_RST
        && pulse_clock_input_select[3:0] == 4'h0 && o_pulse |=> !o_pulse)
        else $error("default pulse longer than one tick");
endmodule : irptx_top
`default_nettype wire

// ==== verif/irptx_led_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// LED driver side: decodes frames and totals pulse and light time
module irptx_led_model (
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_reset,
    // Line inputs
    input  wire logic        i_serial,
    input  wire logic        i_pulse,
    input  wire logic        i_optical,
    // Decoded results
    output logic      [7:0]  o_rx_count,
    output logic      [7:0]  o_rx_byte,
    output logic      [7:0]  o_frame_errs,
    output logic      [15:0] o_pulse_cycles,
    output logic      [15:0] o_light_cycles
);
    logic       busy;
    logic [6:0] tick;
    logic [7:0] shreg;
    // Running totals of pulse and light cycles
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_pulse_cycles <= 16'h0000;
            o_light_cycles <= 16'h0000;
        end else begin
            o_pulse_cycles <= o_pulse_cycles + {15'h0000, i_pulse};
            o_light_cycles <= o_light_cycles + {15'h0000, i_optical};
        end
    end
    // Frame decoder, samples in the middle of each eight-cycle bit
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            busy         <= 1'b0;
            tick         <= 7'h00;
            shreg        <= 8'h00;
            o_rx_count   <= 8'h00;
            o_rx_byte    <= 8'h00;
            o_frame_errs <= 8'h00;
        end else if (!busy) begin
            busy <= ~i_serial;
            tick <= 7'h01;
        end else begin
            tick <= tick + 7'h01;
            if (tick[2:0] == 3'h4) begin  // Mid-bit sample
                if (tick[6:3] == 4'h0 && i_serial) begin
                    busy <= 1'b0;  // Glitch, not a start bit
                end else if (tick[6:3] >= 4'h1 && tick[6:3] <= 4'h8) begin
                    shreg <= {i_serial, shreg[7:1]};  // First data bit is the least significant
                end else if (tick[6:3] == 4'h9) begin
                    busy <= 1'b0;
                    if (i_serial) begin
                        o_rx_count <= o_rx_count + 8'h01;
                        o_rx_byte  <= shreg;
                    end else begin
                        o_frame_errs <= o_frame_errs + 8'h01;
                    end
                end
            end
        end
    end
endmodule : irptx_led_model
`default_nettype wire

// ==== verif/tb_infrared_pulse_transmitter.sv ====
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Register-level bench with a decoding receiver on the line outputs
module tb_infrared_pulse_transmitter;
    import irptx_pkg::*;
    logic        i_mclk  = 1'b0;
    logic        i_reset = 1'b1;
    logic [3:0]  i_addr  = 4'h0;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_wr    = 1'b0;
    logic        i_rd    = 1'b0;
    logic [7:0]  o_rdata, rx_count, rx_byte, frame_errs, q;
    logic        o_irq, o_serial, o_pulse, o_optical;
    logic [15:0] pulse_cycles, light_cycles, p0, l0;
    int          err_total = 0;
    int          checks_done = 0;
    logic [3:0]  ra [16] = '{TX_FUNCTION_SELECT_OFS, TX_CLOCK_INPUT_SELECT_OFS, TX_OUTPUT_ROUTE_OFS,
                             TX_HOLDING_DATA_OFS, TX_SPARE_DATA_OFS, TX_CONTROL_STATUS_OFS,
                             PULSE_FUNCTION_SELECT_OFS, PULSE_CLOCK_INPUT_SELECT_OFS, PULSE_OUTPUT_ROUTE_OFS,
                             PULSE_PERIOD_VALUE_OFS, PULSE_COMPARE_VALUE_OFS, PULSE_CONTROL_OFS,
                             TX_IRQ_ENABLE_OFS, 4'hF, TX_SHIFT_DATA_OFS, PULSE_COUNT_VALUE_OFS};
    logic [7:0]  rv [16] = '{TX_FUNCTION_RST, TX_INPUT_RST, ROUTE_RST, 8'h00, 8'h00, HOLD_EMPTY_MASK,
                             PULSE_FUNCTION_RST, PULSE_INPUT_RST, ROUTE_RST, PULSE_PERIOD_RST,
                             PULSE_COMPARE_RST, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    // Clock
    always #12.5 i_mclk = ~i_mclk;
    // Design and receiver
    irptx_top i_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
                     .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_serial(o_serial), .o_pulse(o_pulse),
                     .o_optical(o_optical));
    irptx_led_model i_led (.i_mclk(i_mclk), .i_reset(i_reset), .i_serial(o_serial), .i_pulse(o_pulse),
                           .i_optical(o_optical), .o_rx_count(rx_count), .o_rx_byte(rx_byte),
                           .o_frame_errs(frame_errs), .o_pulse_cycles(pulse_cycles), .o_light_cycles(light_cycles));
    // =====================================================================
    // Shared tasks
    task automatic tally_and_finish;
        $display("Checks done %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd   <= 1'b0;
        #1 d = o_rdata;
    endtask : rd
    task automatic wait_rx(input logic [7:0] n);
        for (int k = 0; k < 400 && rx_count !== n; k++) @(posedge i_mclk);
        if (rx_count !== n) begin
            err_total++;
            $display("Receiver wait ran out at %0t", $time);
            tally_and_finish();
        end
    endtask : wait_rx
    // =====================================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge i_mclk);
        i_reset <= 1'b0;
        for (int k = 0; k < 16; k++) begin
            rd(ra[k], q);
            chk(q, rv[k]);  // Reset values, halted count and unmapped read
        end
        wr(TX_SPARE_DATA_OFS, 8'hFF);
        rd(TX_SPARE_DATA_OFS, q);
        chk(q, 8'h00);  // Spare register keeps zero
        $display("Test reset values done");
        wr(TX_IRQ_ENABLE_OFS, 8'h01);
        @(posedge i_mclk);
        #1 chk(o_irq, 1'b1);  // Pending empty raises at once
        wr(TX_IRQ_ENABLE_OFS, 8'h00);
        @(posedge i_mclk);
        #1 chk(o_irq, 1'b0);  // Disabled interrupt drops
        $display("Test interrupt enable done");
        wr(TX_HOLDING_DATA_OFS, 8'h55);
        for (int k = 0; k < 100; k++) begin
            @(posedge i_mclk);
            #1 chk(o_serial, 1'b1);  // Nothing leaves while disabled
        end
        rd(TX_CONTROL_STATUS_OFS, q);
        chk(q & HOLD_EMPTY_MASK, 8'h00);  // Byte waits in holding
        $display("Test disabled transmitter done");
        p0 = pulse_cycles;
        l0 = light_cycles;
        wr(TX_IRQ_ENABLE_OFS, 8'h01);  // Interrupt on before the transmitter
        wr(PULSE_CONTROL_OFS, 8'h01);  // Both dividers left at the same ratio
        wr(TX_CONTROL_STATUS_OFS, 8'h01);
        wait_rx(8'h01);
        chk(rx_byte, 8'h55);  // Held byte sent after enable
        chk(pulse_cycles - p0, 16'h0005);  // One tick pulse in each zero bit
        chk(light_cycles - l0, 16'h0005);  // Optical follows the pulse output while the timer runs
        rd(TX_CONTROL_STATUS_OFS, q);
        chk(q, HOLD_EMPTY_MASK | TX_COMPLETE_MASK | 8'h01);  // Status masks
        rd(TX_CONTROL_STATUS_OFS, q);
        chk(q, HOLD_EMPTY_MASK | 8'h01);  // Completion cleared by the read
        $display("Test first frame done");
        wr(TX_IRQ_ENABLE_OFS, 8'h01);
        wr(TX_HOLDING_DATA_OFS, 8'h3C);
        q = 8'h00;
        for (int k = 0; k < 50 && (q & HOLD_EMPTY_MASK) == 8'h00; k++) rd(TX_CONTROL_STATUS_OFS, q);
        chk(q & HOLD_EMPTY_MASK, HOLD_EMPTY_MASK);  // Wait for empty before next byte
        chk(q & TX_COMPLETE_MASK, TX_COMPLETE_MASK);  // Completion confirms the byte started
        wr(TX_HOLDING_DATA_OFS, 8'h81);
        repeat (2) @(posedge i_mclk);
        #1 chk(o_irq, 1'b0);  // Full holding keeps the interrupt low
        for (int k = 0; k < 200 && o_irq !== 1'b1; k++) @(posedge i_mclk);
        #1 chk(o_irq, 1'b1);  // Transfer to shifter raises it
        chk(rx_count, 8'h02);  // First byte finished before the transfer
        chk(rx_byte, 8'h3C);
        wait_rx(8'h03);
        chk(rx_byte, 8'h81);  // Back-to-back byte
        $display("Test back-to-back done");
        wr(TX_IRQ_ENABLE_OFS, 8'h00);
        wr(PULSE_CONTROL_OFS, 8'h00);
        p0 = pulse_cycles;
        l0 = light_cycles;
        wr(TX_HOLDING_DATA_OFS, 8'hF0);
        for (int k = 0; k < 400 && rx_count !== 8'h04; k++) begin
            @(posedge i_mclk);
            #1 chk(o_irq, 1'b0);  // No interrupt while disabled
        end
        wait_rx(8'h04);
        chk(rx_byte, 8'hF0);
        chk(pulse_cycles - p0, 16'h0000);  // Halted timer gives no pulses
        chk(light_cycles - l0, 16'h0028);  // Serial zero bits pass at full width
        $display("Test halted timer done");
        wr(PULSE_COMPARE_VALUE_OFS, 8'h02);
        rd(PULSE_COMPARE_VALUE_OFS, q);
        chk(q, 8'h02);  // Compare register read back
        wr(PULSE_CONTROL_OFS, 8'h01);
        p0 = pulse_cycles;
        l0 = light_cycles;
        wr(TX_HOLDING_DATA_OFS, 8'hA5);
        wait_rx(8'h05);
        chk(rx_byte, 8'hA5);
        chk(pulse_cycles - p0, 16'h000A);  // Numerator widens each pulse
        chk(light_cycles - l0, 16'h000A);
        chk(frame_errs, 8'h00);  // Every stop bit high
        $display("Test pulse width done");
        tally_and_finish();
    end
endmodule : tb_infrared_pulse_transmitter
`default_nettype wire
